// ===== logic/odl_pkg.sv
package odl_pkg;
  // Display memory geometry
  localparam int DEPTH = 256;
  localparam int WORD_W = 12;
  localparam int PTR_W = 8;
  localparam int CODE_W = 7;
  localparam int ATTR_W = 5;
  // Word field positions
  localparam int CODE_HI = 11;
  localparam int CODE_LO = 5;
  localparam int ATTR_HI = 4;
  // Character code classes
  localparam logic [6:0] CODE_FONT_MAX = 7'h7C;
  localparam logic [6:0] CODE_TEST = 7'h7D;
  localparam logic [6:0] CODE_LINE_BREAK = 7'h7E;
  localparam logic [6:0] CODE_BLANK = 7'h7F;
  // Command byte decode
  localparam logic [1:0] BANK_ADDR = 2'h0;
  localparam logic [1:0] BANK_GLYPH = 2'h2;
  localparam logic [3:0] CMD_ADDR_HI = 4'h2;
  localparam logic [3:0] CMD_ADDR_LO = 4'h3;
  localparam logic [2:0] CMD_ATTR = 3'h0;
  localparam logic [7:0] CMD_BANK_SEL = 8'h78;
  // Reset values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [4:0] ATTR_RST = 5'h00;
  localparam logic [6:0] GLYPH_RST = 7'h00;
  localparam logic [1:0] BANK_RST = 2'h0;
  // Glyph matrix
  localparam int GLYPH_COLS = 12;
  localparam int GLYPH_ROWS = 19;
  localparam int ROW_FIRST_SHOWN = 1;
  localparam int ROW_LAST_SHOWN = 18;
  // Code class encoding
  typedef enum logic [1:0] {
    ODL_FONT = 2'h0,
    ODL_TEST = 2'h1,
    ODL_LBRK = 2'h3,
    ODL_BLANK = 2'h2
  } odl_class_t;
endpackage : odl_pkg

// ===== logic/odl_word_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Splits one stored display word into its code class and attribute fields
module odl_word_decode (
  input wire logic [odl_pkg::WORD_W-1:0] word_in,
  output odl_pkg::odl_class_t class_out,
  output logic [3:0] colour_out,
  output logic blink_out,
  output logic [1:0] size_out,
  output logic [1:0] spacing_out,
  output logic end_of_display_out,
  output logic marker_en_out
);
  import odl_pkg::*;
  logic [CODE_W-1:0] code;
  logic [ATTR_W-1:0] attr;
  assign code = word_in[CODE_HI:CODE_LO];
  assign attr = word_in[ATTR_HI:0];
  // Code class from the upper field
  always_comb begin
    if (code <= CODE_FONT_MAX) begin
      class_out = ODL_FONT;
    end else if (code == CODE_TEST) begin
      class_out = ODL_TEST;
    end else if (code == CODE_LINE_BREAK) begin
      class_out = ODL_LBRK;
    end else begin
      class_out = ODL_BLANK;
    end
  end
  // Attribute fields, meaning depends on class
  assign colour_out = attr[4:1];
  assign blink_out = (class_out == ODL_FONT) & attr[0];
  assign size_out = attr[4:3];
  assign spacing_out = attr[2:1];
  assign end_of_display_out = (class_out == ODL_LBRK) & attr[0];
  assign marker_en_out = attr[0];
endmodule : odl_word_decode
`default_nettype wire

// ===== logic/odl_ram.sv
`timescale 1ns/1ps
`default_nettype none
// Display memory: one write port, one registered read port
module odl_ram #(
  parameter int DEPTH = odl_pkg::DEPTH,
  parameter int WIDTH = odl_pkg::WORD_W,
  parameter int AW = odl_pkg::PTR_W
) (
  input wire logic clk_sys_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];
  if (DEPTH != (1 << AW)) begin : g_chk
    $error("odl_ram: depth must equal two to the address width");
  end
  // Write and synchronous read
  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule : odl_ram
`default_nettype wire

// ===== logic/odl_loader.sv
`timescale 1ns/1ps
`default_nettype none
module odl_loader (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic hretrace_in,
  input wire logic vsync_active_in,
  input wire logic [odl_pkg::PTR_W-1:0] rd_addr_in,
  input wire logic [odl_pkg::GLYPH_COLS-1:0] glyph_row_dots_in,
  input wire logic [4:0] glyph_row_in,
  output logic cmd_ready_out,
  output logic [odl_pkg::WORD_W-1:0] rd_word_out,
  output odl_pkg::odl_class_t rd_class_out,
  output logic [3:0] fg_colour_out,
  output logic blink_out,
  output logic [1:0] line_size_out,
  output logic [1:0] line_spacing_out,
  output logic end_of_display_out,
  output logic [3:0] bg_colour_out,
  output logic red_out,
  output logic green_out,
  output logic blue_out,
  output logic intensity_out,
  output logic fast_blank_output,
  output logic record_marker_output,
  output logic [odl_pkg::PTR_W-1:0] ram_write_pointer_out
);
  import odl_pkg::*;

  // Package geometry must match the word and pointer layout used here
  if (CODE_W + ATTR_W != WORD_W) begin : g_chk_word
    $error("odl_loader: code and attribute fields must fill the word");
  end
  if (CODE_HI - CODE_LO + 1 != CODE_W) begin : g_chk_code
    $error("odl_loader: code field position disagrees with its width");
  end
  if (ATTR_HI + 1 != ATTR_W) begin : g_chk_attr
    $error("odl_loader: attribute field must sit at the bottom");
  end
  if (DEPTH != (1 << PTR_W)) begin : g_chk_depth
    $error("odl_loader: pointer must reach every memory word");
  end
  if (PTR_W != 8) begin : g_chk_ptr
    $error("odl_loader: pointer is loaded as two four-bit nibbles");
  end
  if (ROW_LAST_SHOWN > 31) begin : g_chk_row
    $error("odl_loader: glyph row number must fit five bits");
  end

  // Write sequencer: a glyph byte parks in WAIT until a retrace slot
  typedef enum logic [1:0] {
    ODL_IDLE = 2'h0,
    ODL_WAIT = 2'h1,
    ODL_COMMIT = 2'h3
  } odl_state_t;

  // Staging registers and the write sequencer
  odl_state_t state_r, state_nxt;
  logic [PTR_W-1:0] ram_write_pointer_r, ram_write_pointer_nxt;
  logic [ATTR_W-1:0] attribute_staging_r, attribute_staging_nxt;
  logic [CODE_W-1:0] glyph_staging_r, glyph_staging_nxt;
  logic [1:0] bank_r, bank_nxt;
  logic [3:0] bg_r, bg_nxt;
  logic marker_r, marker_nxt;
  // Memory ports and read-side decode
  logic wr_en;
  logic commit_ok;
  logic [WORD_W-1:0] ram_q;
  odl_class_t cls;
  logic [3:0] colour;
  logic blink, eod, mark_en, dot_ok;
  logic [1:0] size, spacing;
  // Pixel path and registered read outputs
  logic [3:0] rgbi_nxt;
  logic [3:0] rgbi_r;
  logic fb_r, fb_nxt, rec_r, rec_nxt;
  logic [WORD_W-1:0] word_r;
  odl_class_t cls_r;
  logic [3:0] fg_r;
  logic blink_r, eod_r;
  logic [1:0] size_r, spacing_r;
  logic ready_r, ready_nxt;
  // Next values of the registered read outputs
  logic [WORD_W-1:0] word_nxt;
  odl_class_t cls_nxt;
  logic [3:0] fg_nxt;
  logic blink_nxt, eod_nxt;
  logic [1:0] size_nxt, spacing_nxt;

  // A write is started by a line retrace outside vertical sync; memory is written one cycle later
  assign commit_ok = hretrace_in && !vsync_active_in;

  // Command decode and staging register loads
  always_comb begin
    state_nxt = state_r;
    ram_write_pointer_nxt = ram_write_pointer_r;
    attribute_staging_nxt = attribute_staging_r;
    glyph_staging_nxt = glyph_staging_r;
    bank_nxt = bank_r;
    wr_en = 1'b0;
    unique case (state_r)
      ODL_IDLE: begin
        // Bank select is decoded whichever bank is current
        if (cmd_valid_in) begin
          if (cmd_byte_in[7:2] == CMD_BANK_SEL[7:2]) begin
            bank_nxt = cmd_byte_in[1:0];
          end else if (bank_r == BANK_GLYPH && cmd_byte_in[7]) begin
            glyph_staging_nxt = cmd_byte_in[6:0];
            state_nxt = ODL_WAIT;
          end else if (!bank_r[0] && cmd_byte_in[7:5] == CMD_ATTR) begin
            attribute_staging_nxt = cmd_byte_in[4:0];
          end else if (bank_r == BANK_ADDR &&
                       cmd_byte_in[7:4] == CMD_ADDR_HI) begin
            ram_write_pointer_nxt[7:4] = cmd_byte_in[3:0];
          end else if (bank_r == BANK_ADDR &&
                       cmd_byte_in[7:4] == CMD_ADDR_LO) begin
            ram_write_pointer_nxt[3:0] = cmd_byte_in[3:0];
          end
        end
      end
      ODL_WAIT: begin
        // Bytes offered now are refused: ready is already low
        if (commit_ok) begin
          state_nxt = ODL_COMMIT;
        end
      end
      ODL_COMMIT: begin
        wr_en = 1'b1;
        // Pointer steps on; location 255 rolls over to 0
        ram_write_pointer_nxt = ram_write_pointer_r + 8'h01;
        state_nxt = ODL_IDLE;
      end
      default: begin
        state_nxt = ODL_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == ODL_IDLE);
  end

  // Loader state registers
  // Reset clears pointer, bank and staging, never the memory contents
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_r <= ODL_IDLE;
      ram_write_pointer_r <= PTR_RST;
      attribute_staging_r <= ATTR_RST;
      glyph_staging_r <= GLYPH_RST;
      bank_r <= BANK_RST;
      ready_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      ram_write_pointer_r <= ram_write_pointer_nxt;
      attribute_staging_r <= attribute_staging_nxt;
      glyph_staging_r <= glyph_staging_nxt;
      bank_r <= bank_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Write port fed from the staging registers, read port for the scan
  odl_ram u_ram (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(wr_en),
    .wr_addr_in(ram_write_pointer_r),
    .wr_data_in({glyph_staging_r, attribute_staging_r}),
    .rd_addr_in(rd_addr_in),
    .rd_data_out(ram_q)
  );

  // Decode of the word on the read port
  odl_word_decode u_dec (
    .word_in(ram_q),
    .class_out(cls),
    .colour_out(colour),
    .blink_out(blink),
    .size_out(size),
    .spacing_out(spacing),
    .end_of_display_out(eod),
    .marker_en_out(mark_en)
  );

  // Glyph dot lookup: rows 1-18 visible, leftmost column is bit 11
  assign dot_ok = (glyph_row_in >= 5'(ROW_FIRST_SHOWN)) &&
                  (glyph_row_in <= 5'(ROW_LAST_SHOWN)) &&
                  glyph_row_dots_in[GLYPH_COLS-1];

  // Pixel outputs and sticky blank-code settings
  always_comb begin
    bg_nxt = bg_r;
    marker_nxt = marker_r;
    rgbi_nxt = 4'h0;
    fb_nxt = 1'b0;
    rec_nxt = 1'b0;
    if (cls == ODL_BLANK) begin
      bg_nxt = colour;
      marker_nxt = mark_en;
    end
    // Line-break, blank and test cells leave every pixel dark
    if (hretrace_in) begin
      rgbi_nxt = 4'h0;
    end else if (cls == ODL_FONT && dot_ok) begin
      rgbi_nxt = colour;
      fb_nxt = 1'b1;
      rec_nxt = marker_r;
    end
  end

  // Read-side next values; size and spacing only follow line breaks
  always_comb begin
    word_nxt = ram_q;
    cls_nxt = cls;
    fg_nxt = colour;
    blink_nxt = blink;
    eod_nxt = eod;
    size_nxt = size_r;
    spacing_nxt = spacing_r;
    if (cls == ODL_LBRK) begin
      size_nxt = size;
      spacing_nxt = spacing;
    end
  end

  // Pixel and blank-code registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      bg_r <= 4'h0;
      marker_r <= 1'b0;
      rgbi_r <= 4'h0;
      fb_r <= 1'b0;
      rec_r <= 1'b0;
    end else begin
      bg_r <= bg_nxt;
      marker_r <= marker_nxt;
      rgbi_r <= rgbi_nxt;
      fb_r <= fb_nxt;
      rec_r <= rec_nxt;
    end
  end

  // Read-side registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      word_r <= '0;
      cls_r <= ODL_FONT;
      fg_r <= 4'h0;
      blink_r <= 1'b0;
      eod_r <= 1'b0;
      size_r <= 2'h0;
      spacing_r <= 2'h0;
    end else begin
      word_r <= word_nxt;
      cls_r <= cls_nxt;
      fg_r <= fg_nxt;
      blink_r <= blink_nxt;
      eod_r <= eod_nxt;
      size_r <= size_nxt;
      spacing_r <= spacing_nxt;
    end
  end

  // Top outputs come straight from their flip-flops
  assign cmd_ready_out = ready_r;
  assign rd_word_out = word_r;
  assign rd_class_out = cls_r;
  assign fg_colour_out = fg_r;
  assign blink_out = blink_r;
  assign line_size_out = size_r;
  assign line_spacing_out = spacing_r;
  assign end_of_display_out = eod_r;
  assign bg_colour_out = bg_r;
  assign red_out = rgbi_r[3];
  assign green_out = rgbi_r[2];
  assign blue_out = rgbi_r[1];
  assign intensity_out = rgbi_r[0];
  assign fast_blank_output = fb_r;
  assign record_marker_output = rec_r;
  assign ram_write_pointer_out = ram_write_pointer_r;
endmodule : odl_loader
`default_nettype wire

// ===== bench/odl_loader_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches command intake, glyph commits and pixel blanking
module odl_loader_checker (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic hretrace_in,
  input wire logic vsync_active_in,
  input wire logic cmd_ready_out,
  input wire logic red_out,
  input wire logic green_out,
  input wire logic blue_out,
  input wire logic intensity_out,
  input wire logic fast_blank_output,
  input wire logic record_marker_output,
  input wire logic [7:0] ram_write_pointer_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic [1:0] bank_r;
  logic [7:0] ptr_at_r;
  logic acc;
  logic pix;
  assign acc = cmd_valid_in && cmd_ready_out;
  assign pix = red_out || green_out || blue_out || intensity_out;
  // Mirrors the command bank and the pointer seen by a taken glyph
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      bank_r <= 2'h0;
      ptr_at_r <= 8'h00;
    end else if (acc && cmd_byte_in[7:2] == 6'h1E) begin
      bank_r <= cmd_byte_in[1:0];
    end else if (acc && cmd_byte_in[7] && bank_r == 2'h2) begin
      ptr_at_r <= ram_write_pointer_out;
    end
  end
  sequence s_glyph;
    acc && cmd_byte_in[7] && bank_r == 2'h2;
  endsequence
  sequence s_blocked;
    (!cmd_ready_out && !(hretrace_in && !vsync_active_in)) [*2];
  endsequence
  property p_addr_hi;
    acc && bank_r == 2'h0 && cmd_byte_in[7:4] == 4'h2
      |=> ram_write_pointer_out[7:4] == $past(cmd_byte_in[3:0]);
  endproperty
  property p_addr_lo;
    acc && bank_r == 2'h0 && cmd_byte_in[7:4] == 4'h3
      |=> ram_write_pointer_out[3:0] == $past(cmd_byte_in[3:0]);
  endproperty
  property p_busy;
    s_glyph |=> !cmd_ready_out;
  endproperty
  property p_wait;
    s_blocked |=> !cmd_ready_out;
  endproperty
  property p_inc;
    $rose(cmd_ready_out) |-> ram_write_pointer_out == ptr_at_r + 8'h01;
  endproperty
  property p_wrap;
    $rose(cmd_ready_out) && ptr_at_r == 8'hFF
      |-> ram_write_pointer_out == 8'h00;
  endproperty
  property p_dark;
    hretrace_in |=> !pix && !fast_blank_output && !record_marker_output;
  endproperty
  property p_bank_hi;
    acc && bank_r == 2'h2 && cmd_byte_in[7:4] == 4'h2
      |=> $stable(ram_write_pointer_out);
  endproperty
  property p_bank_glyph;
    acc && bank_r == 2'h0 && cmd_byte_in[7] |=> cmd_ready_out;
  endproperty
  a_addr_hi: assert property (p_addr_hi)
    else $error("address high nibble not loaded");
  a_addr_lo: assert property (p_addr_lo)
    else $error("address low nibble not loaded");
  a_busy: assert property (p_busy)
    else $error("glyph command did not start a write");
  a_wait: assert property (p_wait)
    else $error("write finished outside retrace");
  a_inc: assert property (p_inc)
    else $error("pointer not advanced by one");
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap to zero");
  a_dark: assert property (p_dark)
    else $error("pixel output active in retrace");
  a_bank_hi: assert property (p_bank_hi)
    else $error("address byte taken outside its bank");
  a_bank_glyph: assert property (p_bank_glyph)
    else $error("glyph byte taken outside its bank");
endmodule : odl_loader_checker
`default_nettype wire

// ===== bench/odl_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side: offers command bytes one at a time
module odl_mcu_model (
  input wire logic clk_sys_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [7:0] byte_out
);
  initial begin
    valid_out = 1'b0;
    byte_out = 8'hA5;
  end
  // Holds the byte until an edge that sees the loader ready
  task automatic send(input logic [7:0] b);
    valid_out = 1'b1;
    byte_out = b;
    while (!ready_in) begin
      @(posedge clk_sys_in);
      #1;
    end
    @(posedge clk_sys_in);
    #1;
    valid_out = 1'b0;
    byte_out = ~b;  // Released line shows no stale byte
    // Let one edge pass so the next byte never lands in this time step
    @(posedge clk_sys_in);
    #1;
  endtask : send
  // Start location may be any of 0 to 255
  task automatic set_ptr(input logic [7:0] p);
    send({4'h2, p[7:4]});
    send({4'h3, p[3:0]});
  endtask : set_ptr
  task automatic bank(input logic [1:0] b);
    send({6'h1E, b});
  endtask : bank
  task automatic glyph(input logic [6:0] c);
    send({1'b1, c});
  endtask : glyph
endmodule : odl_mcu_model
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import odl_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic hretrace_in = 1'b0;
  logic vsync_active_in = 1'b0;
  logic [2:0] hcnt = 3'h0;
  logic [7:0] rd_addr_in = 8'h00;
  logic cmd_valid_in, cmd_ready_out, blink_out, eod;
  logic [7:0] cmd_byte_in, ptr;
  logic [11:0] rd_word_out;
  odl_class_t rd_class_out;
  logic [3:0] fg, bg;
  logic [1:0] size, spc;
  logic [11:0] dots = 12'h800;
  logic [4:0] row = 5'h05;
  logic red, grn, blu, inten, fb, rec;
  int mismatches = 0;
  int checks_done = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  // Retrace two cycles out of every eight
  always @(posedge clk_sys_in) begin
    #1;
    hcnt = hcnt + 3'h1;
    hretrace_in = (hcnt < 3'h2);
  end
  odl_mcu_model mcu_i (.clk_sys_in(clk_sys_in), .ready_in(cmd_ready_out),
    .valid_out(cmd_valid_in), .byte_out(cmd_byte_in));
  odl_loader odl_loader_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in),
    .hretrace_in(hretrace_in), .vsync_active_in(vsync_active_in),
    .rd_addr_in(rd_addr_in), .glyph_row_dots_in(dots),
    .glyph_row_in(row), .cmd_ready_out(cmd_ready_out),
    .rd_word_out(rd_word_out), .rd_class_out(rd_class_out),
    .fg_colour_out(fg), .blink_out(blink_out), .line_size_out(size),
    .line_spacing_out(spc), .end_of_display_out(eod),
    .bg_colour_out(bg), .red_out(red), .green_out(grn), .blue_out(blu),
    .intensity_out(inten), .fast_blank_output(fb),
    .record_marker_output(rec),
    .ram_write_pointer_out(ptr));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_cls(input odl_class_t got, input odl_class_t exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t class %h expected %h", $time, got, exp);
    end
  endtask : chk_cls
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // Waits, bounded, for the loader to finish a pending write
  task automatic wait_idle;
    for (int n = 0; n < 200 && !cmd_ready_out; n++) begin
      @(posedge clk_sys_in);
      #1;
    end
    if (!cmd_ready_out) begin
      mismatches++;
      $display("BAD %0t write never finished", $time);
    end
  endtask : wait_idle
  task automatic wr(input logic [6:0] c);
    mcu_i.glyph(c);
    wait_idle();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [11:0] w,
      input odl_class_t cls);
    rd_addr_in = a;
    repeat (4) @(posedge clk_sys_in);
    #1;
    chk(rd_word_out, w);
    chk_cls(rd_class_out, cls);
  endtask : rd
  // Samples the pixel outputs after an edge that saw no retrace
  task automatic pix(input logic [11:0] exp);
    @(posedge clk_sys_in);
    while (hretrace_in) begin
      @(posedge clk_sys_in);
    end
    #1;
    chk({6'h0, red, grn, blu, inten, fb, rec}, exp);
  endtask : pix
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    mcu_i.set_ptr(8'hFE);
    mcu_i.send(8'h15);
    mcu_i.bank(2'h2);
    chk({4'h0, ptr}, 12'h0FE);
    wr(7'h7C);
    chk({4'h0, ptr}, 12'h0FF);
    wr(7'h7D);
    chk({4'h0, ptr}, 12'h000);
    mcu_i.send(8'h1B);
    wr(7'h7E);
    mcu_i.send(8'h0B);
    vsync_active_in = 1'b1;
    mcu_i.glyph(7'h7F);
    repeat (20) @(posedge clk_sys_in);
    #1;
    chk({3'h0, cmd_ready_out, ptr}, 12'h001);
    vsync_active_in = 1'b0;
    wait_idle();
    mcu_i.send(8'h25);
    chk({4'h0, ptr}, 12'h002);
    mcu_i.bank(2'h0);
    mcu_i.send(8'h85);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk({3'h0, cmd_ready_out, ptr}, 12'h102);
    rd(8'hFE, {7'h7C, 5'h15}, ODL_FONT);
    chk({7'h0, fg, blink_out}, 12'h015);
    rd(8'hFF, {7'h7D, 5'h15}, ODL_TEST);
    rd(8'h00, {7'h7E, 5'h1B}, ODL_LBRK);
    chk({7'h0, size, spc, eod}, 12'h01B);
    rd(8'h01, {7'h7F, 5'h0B}, ODL_BLANK);
    chk({8'h0, bg}, 12'h005);
    rd(8'hFE, {7'h7C, 5'h15}, ODL_FONT);
    pix(12'h02B);
    row = 5'h00;
    pix(12'h000);
    row = 5'h12;
    pix(12'h02B);
    dots = 12'h7FF;
    pix(12'h000);
    end_sim();
  end
endmodule : tb_top
bind odl_loader odl_loader_checker odl_loader_checker_i (.*);
`default_nettype wire
